// ===== core/lpw_map.svh
// register offsets, field positions, reset values and timing for the power controller
`ifndef LPW_MAP_SVH
`define LPW_MAP_SVH

`define LPW_OFF_CTRL      8'h00
`define LPW_OFF_STAT      8'h04
`define LPW_OFF_RISE      8'h08
`define LPW_OFF_FALL      8'h0c
`define LPW_OFF_MASK      8'h10
`define LPW_OFF_PEND      8'h14
`define LPW_OFF_SEL0      8'h20
`define LPW_OFF_SEL3      8'h2c

`define LPW_CTRL_LP_STOP  0
`define LPW_CTRL_STANDBY  1
`define LPW_CTRL_PVD_EN   2
`define LPW_CTRL_STOP     3

`define LPW_STAT_STATE_LO 0
`define LPW_STAT_LP_REG   4
`define LPW_STAT_PVD      5
`define LPW_STAT_IO2_LOW  6
`define LPW_STAT_SB_FLAG  7
`define LPW_STAT_SUP_LOW  8

`define LPW_CTRL_RESET    4'h0
`define LPW_EDGE_RESET    32'h0000_0000
`define LPW_MASK_RESET    32'h0000_0000
`define LPW_SEL_RESET     7'h00

`define LPW_CLK_MHZ       100
`define LPW_REG_SETTLE_NS 1000
`define LPW_REG_SETTLE_CYC ((`LPW_REG_SETTLE_NS * `LPW_CLK_MHZ + 999) / 1000)

`define LPW_LINE_PVD      16
`define LPW_LINE_IO2      31

`endif

// ===== core/lpw_pkg.sv
// types shared by the power and wakeup controller
package lpw_pkg;
  typedef enum logic [2:0] {
    LPW_RUN,
    LPW_SLEEP,
    LPW_STOP,
    LPW_STOP_REGUP,
    LPW_STANDBY,
    LPW_WAKE
  } lpw_state_t;
endpackage : lpw_pkg

// ===== core/lpw_edge_line.sv
// one wakeup line: asynchronous edge capture, synchroniser and edge pulse
`timescale 1ns/1ns
module lpw_edge_line (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic line_in,
  input  wire logic rise_en,
  input  wire logic fall_en,
  output logic      det
);
  logic rise_tgl_q;
  logic fall_tgl_q;
  logic [2:0] rise_sync_q;
  logic [2:0] fall_sync_q;

  // pin itself clocks the toggle, so pulses shorter than clk are kept
  always_ff @(posedge line_in or posedge reset) begin
    if (reset) rise_tgl_q <= 1'b0;
    else rise_tgl_q <= ~rise_tgl_q;
  end

  always_ff @(negedge line_in or posedge reset) begin
    if (reset) fall_tgl_q <= 1'b0;
    else fall_tgl_q <= ~fall_tgl_q;
  end

  // stage 0 is only read by stage 1
  always_ff @(posedge clk) begin
    if (reset) begin
      rise_sync_q <= 3'h0;
      fall_sync_q <= 3'h0;
    end else begin
      rise_sync_q <= {rise_sync_q[1:0], rise_tgl_q};
      fall_sync_q <= {fall_sync_q[1:0], fall_tgl_q};
    end
  end

  assign det = (rise_en & (rise_sync_q[2] ^ rise_sync_q[1]))
             | (fall_en & (fall_sync_q[2] ^ fall_sync_q[1]));
endmodule : lpw_edge_line

// ===== core/lpw_ctrl.sv
// low-power mode sequencer, supply supervision and 32-line wakeup controller
`timescale 1ns/1ns
`include "lpw_map.svh"

//
// Contract
// - hold chip reset while supply low
// - supervisors always on, analog part optional
// - detector interrupt on rise, fall, both
// - regulator enabled, main mode after reset
// - sleep gates cpu clock, any interrupt wakes
// - stop gates core clocks and oscillators
// - any enabled line wakes from stop
// - regulator to main before rc clock
// - standby powers off regulator and core
// - standby exit: reset, watchdog, wake pin, rtc
// - rtc and watchdog clocks never stopped
// - io supply low disables io, line 31
// - 32 lines, rising/falling/both selectable
// - independent mask per line
// - pending holds requests until cleared
// - asynchronous capture of narrow pulses
// - selector routes 88 pins to 16 lines
module lpw_ctrl
  import lpw_pkg::*;
#(
  parameter int NPINS      = 88,
  parameter int SETTLE_CYC = `LPW_REG_SETTLE_CYC
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic [31:0]           prdata,
  output logic                  pslverr,
  output logic                  irq,
  input  wire logic [NPINS-1:0] gpio_in,
  input  wire logic [13:0]      periph_line,
  input  wire logic             periph_rc_req,
  input  wire logic             core_lp_req,
  input  wire logic             core_irq_any,
  input  wire logic             por_vdd_low,
  input  wire logic             pdr_vdd_low,
  input  wire logic             pdr_vdda_low,
  input  wire logic             opt_vdda_mon_off,
  input  wire logic             pvd_below,
  input  wire logic             io2_below,
  input  wire logic             external_reset_pin_n,
  input  wire logic             independent_watchdog_rst,
  input  wire logic             standby_wakeup_pin,
  input  wire logic             rtc_event,
  output logic                  chip_reset,
  output logic                  cpu_clk_en,
  output logic                  core_clk_en,
  output logic                  core_pwr_en,
  output logic                  regulator_en,
  output logic                  low_power_regulator_mode,
  output logic                  internal_rc_8mhz_osc_en,
  output logic                  external_crystal_osc_en,
  output logic                  pll_en,
  output logic                  periph_rc_grant,
  output logic                  always_on_clk_en,
  output logic                  io2_disable
);
  localparam int SW = 7;

  // pin-side levels pass two flops before use
  logic [1:0] sup_s_q, vda_s_q, opt_s_q, pvd_s_q, io2_s_q, external_reset_pin_s_q, wdg_s_q, wk_s_q;
  logic       wk_prev_q;

  lpw_state_t state_q;
  logic [3:0]  ctrl_q;
  logic [31:0] rise_q, fall_q, mask_q, pend_q;
  logic [SW-1:0] sel_q [16];
  logic [15:0] cnt_q;
  logic        sb_flag_q;
  logic        regs_clr;
  logic [31:0] line_raw, det;
  logic [15:0] ext_line;
  logic        sup_low, wr_en, acc, addr_ok;
  logic        sb_wake;
  logic [31:0] rd_d;

  always_ff @(posedge clk) begin
    if (reset) begin
      sup_s_q  <= 2'h0;
      vda_s_q  <= 2'h0;
      opt_s_q  <= 2'h0;
      pvd_s_q  <= 2'h0;
      io2_s_q  <= 2'h0;
      external_reset_pin_s_q <= 2'h3;
      wdg_s_q  <= 2'h0;
      wk_s_q   <= 2'h0;
    end else begin
      sup_s_q  <= {sup_s_q[0], por_vdd_low | pdr_vdd_low};
      vda_s_q  <= {vda_s_q[0], pdr_vdda_low};
      opt_s_q  <= {opt_s_q[0], opt_vdda_mon_off};
      pvd_s_q  <= {pvd_s_q[0], pvd_below};
      io2_s_q  <= {io2_s_q[0], io2_below};
      external_reset_pin_s_q <= {external_reset_pin_s_q[0], external_reset_pin_n};
      wdg_s_q  <= {wdg_s_q[0], independent_watchdog_rst};
      wk_s_q   <= {wk_s_q[0], standby_wakeup_pin};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) wk_prev_q <= 1'b0;
    else wk_prev_q <= wk_s_q[1];
  end

  // analog supervisor may be switched off by option
  assign sup_low = sup_s_q[1] | (vda_s_q[1] & ~opt_s_q[1]);

  assign sb_wake = ~external_reset_pin_s_q[1] | wdg_s_q[1] | (wk_s_q[1] & ~wk_prev_q) | rtc_event;

  // core-domain registers lost while core held in reset
  assign regs_clr = reset | chip_reset;

  // pin selector ahead of asynchronous capture; mux glitches may log an edge
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_sel
      assign ext_line[g] = (int'(sel_q[g]) < NPINS) ? gpio_in[sel_q[g]] : 1'b0;
    end
  endgenerate

  // io supply monitor feeds line 31
  // detector output gated by its enable, edges from line 16 config
  assign line_raw = {io2_below, periph_line, pvd_below & ctrl_q[`LPW_CTRL_PVD_EN], ext_line};

  generate
    for (g = 0; g < 32; g++) begin : g_line
      lpw_edge_line u_line (
        .clk     (clk),
        .reset   (reset),
        .line_in (line_raw[g]),
        .rise_en (rise_q[g]),
        .fall_en (fall_q[g]),
        .det     (det[g])
      );
    end
  endgenerate

  // apb: answer one cycle into the access phase
  assign acc     = psel & penable & pready;
  assign wr_en   = acc & pwrite & addr_ok;
  assign addr_ok = (paddr[1:0] == 2'b00) &&
                   ((paddr <= `LPW_OFF_PEND) ||
                    (paddr >= `LPW_OFF_SEL0 && paddr <= `LPW_OFF_SEL3));

  always_ff @(posedge clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok;
      prdata  <= (psel & penable & ~pready & ~pwrite & addr_ok) ? rd_d : 32'h0000_0000;
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    case (paddr)
      `LPW_OFF_CTRL: rd_d = {28'h0, ctrl_q};
      `LPW_OFF_STAT: begin
        rd_d[`LPW_STAT_STATE_LO +: 3] = state_q;
        rd_d[`LPW_STAT_LP_REG]  = low_power_regulator_mode;
        rd_d[`LPW_STAT_PVD]     = pvd_s_q[1];
        rd_d[`LPW_STAT_IO2_LOW] = io2_s_q[1];
        rd_d[`LPW_STAT_SB_FLAG] = sb_flag_q;
        rd_d[`LPW_STAT_SUP_LOW] = sup_low;
      end
      `LPW_OFF_RISE: rd_d = rise_q;
      `LPW_OFF_FALL: rd_d = fall_q;
      `LPW_OFF_MASK: rd_d = mask_q;
      `LPW_OFF_PEND: rd_d = pend_q;
      default: begin
        if (paddr >= `LPW_OFF_SEL0 && paddr <= `LPW_OFF_SEL3) begin
          for (int k = 0; k < 4; k++) begin
            rd_d[8*k +: 8] = {1'b0, sel_q[4*int'(paddr[3:2]) + k]};
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (regs_clr) ctrl_q <= `LPW_CTRL_RESET;
    else if (wr_en && paddr == `LPW_OFF_CTRL) ctrl_q <= pwdata[3:0];
  end

  always_ff @(posedge clk) begin
    if (regs_clr) begin
      rise_q <= `LPW_EDGE_RESET;
      fall_q <= `LPW_EDGE_RESET;
    end else begin
      if (wr_en && paddr == `LPW_OFF_RISE) rise_q <= pwdata;
      if (wr_en && paddr == `LPW_OFF_FALL) fall_q <= pwdata;
    end
  end

  always_ff @(posedge clk) begin
    if (regs_clr) mask_q <= `LPW_MASK_RESET;
    else if (wr_en && paddr == `LPW_OFF_MASK) mask_q <= pwdata;
  end

  // sticky pending, write one clears, new edge wins
  always_ff @(posedge clk) begin
    if (regs_clr) begin
      pend_q <= 32'h0000_0000;
    end else if (wr_en && paddr == `LPW_OFF_PEND) begin
      pend_q <= (pend_q & ~pwdata) | (det & mask_q);
    end else begin
      pend_q <= pend_q | (det & mask_q);
    end
  end

  always_ff @(posedge clk) begin
    if (regs_clr) begin
      for (int k = 0; k < 16; k++) sel_q[k] <= `LPW_SEL_RESET;
    end else if (wr_en && paddr >= `LPW_OFF_SEL0 && paddr <= `LPW_OFF_SEL3) begin
      for (int k = 0; k < 4; k++) begin
        sel_q[4*int'(paddr[3:2]) + k] <= pwdata[8*k +: SW];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) irq <= 1'b0;
    else irq <= |(pend_q & mask_q);
  end

  // standby flag survives the core reset; cleared by software writing one to bit 7
  always_ff @(posedge clk) begin
    if (reset) sb_flag_q <= 1'b0;
    else if (state_q == LPW_STANDBY) sb_flag_q <= 1'b1;
    else if (wr_en && paddr == `LPW_OFF_STAT && pwdata[`LPW_STAT_SB_FLAG]) sb_flag_q <= 1'b0;
  end

  // sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= LPW_RUN;
      cnt_q   <= 16'h0000;
    end else if (sup_low) begin
      // brown-out restarts the sequencer, else a stop with cleared mask never ends
      state_q <= LPW_RUN;
      cnt_q   <= 16'h0000;
    end else begin
      case (state_q)
        LPW_RUN: begin
          cnt_q <= 16'h0000;
          if (core_lp_req && !sup_low) begin
            if (!ctrl_q[`LPW_CTRL_STANDBY] && ctrl_q[`LPW_CTRL_STOP]) state_q <= LPW_STOP;
            else if (ctrl_q[`LPW_CTRL_STANDBY]) state_q <= LPW_STANDBY;
            else state_q <= LPW_SLEEP;
          end
        end
        // any interrupt or event ends sleep
        LPW_SLEEP: begin
          if (core_irq_any || |(det & mask_q)) state_q <= LPW_RUN;
        end
        LPW_STOP: begin
          if (|(det & mask_q)) state_q <= LPW_RUN;
          else if (periph_rc_req) state_q <= LPW_STOP_REGUP;
        end
        LPW_STOP_REGUP: begin
          if (cnt_q != 16'(SETTLE_CYC)) cnt_q <= cnt_q + 16'h0001;
          if (|(det & mask_q)) state_q <= LPW_RUN;
          else if (!periph_rc_req) begin
            state_q <= LPW_STOP;
            cnt_q   <= 16'h0000;
          end
        end
        LPW_STANDBY: begin
          cnt_q <= 16'h0000;
          if (sb_wake) state_q <= LPW_WAKE;
        end
        // regulator settles before core reset lifts
        LPW_WAKE: begin
          if (cnt_q == 16'(SETTLE_CYC) && !sup_low) state_q <= LPW_RUN;
          else if (cnt_q != 16'(SETTLE_CYC)) cnt_q <= cnt_q + 16'h0001;
        end
        default: state_q <= LPW_RUN;
      endcase
    end
  end

  // reset held while supply low, no external circuit
  always_ff @(posedge clk) begin
    if (reset) chip_reset <= 1'b1;
    else chip_reset <= sup_low || state_q == LPW_STANDBY || state_q == LPW_WAKE;
  end

  // sleep only stops the cpu clock
  always_ff @(posedge clk) begin
    if (reset) cpu_clk_en <= 1'b0;
    else cpu_clk_en <= state_q == LPW_RUN;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      core_clk_en <= 1'b0;
      pll_en      <= 1'b0;
      external_crystal_osc_en <= 1'b0;
    end else begin
      core_clk_en <= state_q == LPW_RUN || state_q == LPW_SLEEP;
      pll_en      <= state_q == LPW_RUN || state_q == LPW_SLEEP;
      external_crystal_osc_en <= state_q == LPW_RUN || state_q == LPW_SLEEP;
    end
  end

  // rc clock reaches the peripheral only once regulator settled
  always_ff @(posedge clk) begin
    if (reset) begin
      internal_rc_8mhz_osc_en <= 1'b1;
      periph_rc_grant         <= 1'b0;
    end else begin
      internal_rc_8mhz_osc_en <= state_q == LPW_RUN || state_q == LPW_SLEEP ||
                                 state_q == LPW_WAKE ||
                                 (state_q == LPW_STOP_REGUP && cnt_q == 16'(SETTLE_CYC));
      periph_rc_grant         <= state_q == LPW_STOP_REGUP && cnt_q == 16'(SETTLE_CYC);
    end
  end

  // regulator off in standby, low-power only if chosen for stop
  always_ff @(posedge clk) begin
    if (reset) begin
      regulator_en             <= 1'b1;
      core_pwr_en              <= 1'b1;
      low_power_regulator_mode <= 1'b0;
    end else begin
      regulator_en             <= state_q != LPW_STANDBY;
      core_pwr_en              <= state_q != LPW_STANDBY;
      low_power_regulator_mode <= state_q == LPW_STOP && ctrl_q[`LPW_CTRL_LP_STOP];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) always_on_clk_en <= 1'b1;
    else always_on_clk_en <= 1'b1;
  end

  // hardware disables io rail when low
  always_ff @(posedge clk) begin
    if (reset) io2_disable <= 1'b1;
    else io2_disable <= io2_s_q[1];
  end
endmodule : lpw_ctrl

// ===== verif/lpw_ctrl_assertions.sv
// port-level assertions for the power and wakeup controller
`timescale 1ns/1ns
module lpw_ctrl_checker #(
  parameter int SETTLE_CYC = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic por_vdd_low,
  input wire logic pdr_vdda_low,
  input wire logic opt_vdda_mon_off,
  input wire logic core_irq_any,
  input wire logic io2_below,
  input wire logic chip_reset,
  input wire logic cpu_clk_en,
  input wire logic core_clk_en,
  input wire logic core_pwr_en,
  input wire logic regulator_en,
  input wire logic low_power_regulator_mode,
  input wire logic internal_rc_8mhz_osc_en,
  input wire logic external_crystal_osc_en,
  input wire logic pll_en,
  input wire logic periph_rc_grant,
  input wire logic always_on_clk_en,
  input wire logic io2_disable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  low_supply_a: assert property (por_vdd_low [*4] |-> chip_reset)
    else $error("chip reset not held under low main supply");
  analog_mon_a: assert property ((pdr_vdda_low && !opt_vdda_mon_off) [*4] |-> chip_reset)
    else $error("chip reset not held under low analog supply");
  reg_after_reset_a: assert property ($fell(reset) |-> regulator_en && !low_power_regulator_mode)
    else $error("regulator not on in main mode after reset");
  sleep_wake_a: assert property (
    !chip_reset && !cpu_clk_en && core_clk_en && core_irq_any |-> ##[1:3] cpu_clk_en)
    else $error("interrupt did not wake the processor from sleep");
  stop_gating_a: assert property (low_power_regulator_mode |-> !core_clk_en && !pll_en &&
    !external_crystal_osc_en && !internal_rc_8mhz_osc_en)
    else $error("clock or oscillator running in stop");
  // grant may only follow a settled main-mode regulator
  rc_main_first_a: assert property ($rose(periph_rc_grant) |->
    !low_power_regulator_mode && !$past(low_power_regulator_mode, 3))
    else $error("rc clock granted before regulator back in main mode");
  standby_off_a: assert property (!core_pwr_en |-> !regulator_en && !pll_en &&
    !internal_rc_8mhz_osc_en && !external_crystal_osc_en)
    else $error("regulator or oscillator on with core powered off");
  always_on_a: assert property (always_on_clk_en)
    else $error("always-on clock stopped");
  io2_cut_a: assert property (io2_below [*4] |-> io2_disable)
    else $error("io rail low but its pins not disabled");
  full_reset_a: assert property ($fell(chip_reset) |->
    regulator_en && core_pwr_en && !low_power_regulator_mode)
    else $error("core left reset without main regulator");

  grant_c: cover property ($rose(periph_rc_grant));
  standby_c: cover property ($fell(core_pwr_en));
  sleep_c: cover property ($fell(cpu_clk_en) && core_clk_en);
endmodule : lpw_ctrl_checker

bind lpw_ctrl lpw_ctrl_checker #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.clk, .reset, .por_vdd_low,
  .pdr_vdda_low, .opt_vdda_mon_off, .core_irq_any, .io2_below, .chip_reset, .cpu_clk_en,
  .core_clk_en, .core_pwr_en, .regulator_en, .low_power_regulator_mode,
  .internal_rc_8mhz_osc_en, .external_crystal_osc_en, .pll_en, .periph_rc_grant,
  .always_on_clk_en, .io2_disable);

// ===== verif/lpw_src_model.sv
// wakeup-source peripheral model: short line pulses and rc clock request
`timescale 1ns/1ns
module lpw_src_model (
  input  wire logic   clk,
  input  wire logic   pulse_go,
  input  wire logic   rc_want,
  input  wire logic   periph_rc_grant,
  output logic [13:0] periph_line,
  output logic        periph_rc_req
);
  initial periph_line = 14'h0000;
  initial periph_rc_req = 1'b0;
  always @(posedge pulse_go) begin
    #2 periph_line[0] = 1'b1;
    #3 periph_line[0] = 1'b0;
  end
  always @(posedge clk) periph_rc_req <= rc_want | (periph_rc_req & ~periph_rc_grant);
endmodule : lpw_src_model

// ===== verif/low_power_mode_and_wakeup_ctrl_tb_top.sv
// self-checking bench for the low-power and wakeup controller
`timescale 1ns/1ns
`include "lpw_map.svh"
module low_power_mode_and_wakeup_ctrl_tb_top import lpw_pkg::*;;
  logic        clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [87:0] gpio_in;
  logic [13:0] periph_line;
  logic        core_lp_req = 1'b0, core_irq_any = 1'b0, por_vdd_low = 1'b0, pdr_vdd_low = 1'b0;
  logic        pdr_vdda_low = 1'b0, opt_vdda_mon_off = 1'b0, pvd_below = 1'b0, io2_below = 1'b0;
  logic        external_reset_pin_n = 1'b1, independent_watchdog_rst = 1'b0, rtc_event = 1'b0;
  logic        standby_wakeup_pin = 1'b0, pulse_go = 1'b0, rc_want = 1'b0, periph_rc_req;
  logic        pready, pslverr, irq, chip_reset, cpu_clk_en, core_clk_en, core_pwr_en;
  logic        regulator_en, low_power_regulator_mode, internal_rc_8mhz_osc_en, pll_en;
  logic        external_crystal_osc_en, periph_rc_grant, always_on_clk_en, io2_disable;
  logic [33:0] q[$];
  logic [33:0] e;
  int          seed = 32'h881b3597;
  int          p, i, k, miscompares = 0, n_tests = 0;
  wire logic [3:0] ev = {chip_reset, cpu_clk_en, core_pwr_en, periph_rc_grant};

  // short settle count keeps regulator waits brief
  lpw_ctrl #(.SETTLE_CYC(4)) u_dut (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .irq(irq), .gpio_in(gpio_in), .periph_line(periph_line), .periph_rc_req(periph_rc_req),
    .core_lp_req(core_lp_req), .core_irq_any(core_irq_any), .por_vdd_low(por_vdd_low),
    .pdr_vdd_low(pdr_vdd_low), .pdr_vdda_low(pdr_vdda_low),
    .opt_vdda_mon_off(opt_vdda_mon_off), .pvd_below(pvd_below), .io2_below(io2_below),
    .external_reset_pin_n(external_reset_pin_n),
    .independent_watchdog_rst(independent_watchdog_rst),
    .standby_wakeup_pin(standby_wakeup_pin), .rtc_event(rtc_event), .chip_reset(chip_reset),
    .cpu_clk_en(cpu_clk_en), .core_clk_en(core_clk_en), .core_pwr_en(core_pwr_en),
    .regulator_en(regulator_en), .low_power_regulator_mode(low_power_regulator_mode),
    .internal_rc_8mhz_osc_en(internal_rc_8mhz_osc_en),
    .external_crystal_osc_en(external_crystal_osc_en), .pll_en(pll_en),
    .periph_rc_grant(periph_rc_grant), .always_on_clk_en(always_on_clk_en),
    .io2_disable(io2_disable)
  );
  lpw_src_model u_src (
    .clk(clk), .pulse_go(pulse_go), .rc_want(rc_want), .periph_rc_grant(periph_rc_grant),
    .periph_line(periph_line), .periph_rc_req(periph_rc_req)
  );

  always #5 clk = ~clk;

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // x holds {check data, expect error, data}; the monitor pops it on completion
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] x);
    q.push_back(x);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 50 && pready !== 1'b1; k++) @(posedge clk);
    if (pready !== 1'b1) chk("pready", 1'b1, pready);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h0);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, {2'b10, x});
  endtask : rd

  task wfor(input int b, input logic v);
    for (k = 0; k < 300 && ev[b] !== v; k++) @(posedge clk);
    chk("wait", v, ev[b]);
  endtask : wfor

  task summarize;
    if (miscompares == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      e = q.pop_front();
      chk("pslverr", e[32], pslverr);
      if (e[33])
        chk("prdata", e[31:0], prdata);
    end
  end

  initial begin
    #200000;
    miscompares++;
    summarize;
  end

  initial begin
    p = $unsigned($random(seed)) % 88;
    gpio_in = 88'({$random(seed), $random(seed), $random(seed)});
    // selected pin starts low so its first change is a rising edge
    gpio_in[p] = 1'b0;
    cyc(8);
    reset <= 1'b0;
    wfor(3, 1'b0);
    chk("reg_en", 1'b1, regulator_en);
    chk("lp_mode", 1'b0, low_power_regulator_mode);
    apb(1'b0, 8'h18, 32'h0, 34'h3_0000_0000);
    apb(1'b1, 8'h01, 32'hffff_ffff, 34'h1_0000_0000);
    rd(`LPW_OFF_CTRL, 32'h0);
    rd(`LPW_OFF_MASK, 32'h0);
    wr(`LPW_OFF_SEL0, p);
    rd(`LPW_OFF_SEL0, p);
    wr(`LPW_OFF_RISE, 32'h0002_0001);
    wr(`LPW_OFF_FALL, 32'h0000_0001);
    wr(`LPW_OFF_MASK, 32'h0000_0001);
    gpio_in[p] <= 1'b1;
    pulse_go <= 1'b1;
    cyc(8);
    pulse_go <= 1'b0;
    rd(`LPW_OFF_PEND, 32'h1);
    chk("irq", 1'b1, irq);
    wr(`LPW_OFF_PEND, 32'h1);
    wr(`LPW_OFF_MASK, 32'h0002_0001);
    gpio_in[p] <= 1'b0;
    pulse_go <= 1'b1;
    cyc(8);
    rd(`LPW_OFF_PEND, 32'h0002_0001);
    wr(`LPW_OFF_PEND, 32'hffff_ffff);
    rd(`LPW_OFF_PEND, 32'h0);
    chk("irq", 1'b0, irq);
    // stop with low-power regulator, then an rc request
    wr(`LPW_OFF_CTRL, 32'h9);
    core_lp_req <= 1'b1;
    cyc(1);
    core_lp_req <= 1'b0;
    cyc(3);
    chk("core_clk", 1'b0, core_clk_en);
    chk("lp_mode", 1'b1, low_power_regulator_mode);
    chk("pll", 1'b0, pll_en);
    chk("xtal", 1'b0, external_crystal_osc_en);
    chk("rc_osc", 1'b0, internal_rc_8mhz_osc_en);
    rc_want <= 1'b1;
    wfor(0, 1'b1);
    chk("rc_osc", 1'b1, internal_rc_8mhz_osc_en);
    rc_want <= 1'b0;
    chk("lp_mode", 1'b0, low_power_regulator_mode);
    gpio_in[p] <= 1'b1;
    wfor(2, 1'b1);
    rd(`LPW_OFF_STAT, 32'h0);
    // stop with the regulator left in main mode, woken by a falling edge
    wr(`LPW_OFF_CTRL, 32'h8);
    core_lp_req <= 1'b1;
    cyc(1);
    core_lp_req <= 1'b0;
    cyc(3);
    chk("core_clk", 1'b0, core_clk_en);
    chk("lp_mode", 1'b0, low_power_regulator_mode);
    gpio_in[p] <= 1'b0;
    wfor(2, 1'b1);
    wr(`LPW_OFF_CTRL, 32'h0);
    core_lp_req <= 1'b1;
    cyc(1);
    core_lp_req <= 1'b0;
    cyc(3);
    chk("cpu_clk", 1'b0, cpu_clk_en);
    chk("core_clk", 1'b1, core_clk_en);
    rd(`LPW_OFF_STAT, {29'h0, LPW_SLEEP});
    core_irq_any <= 1'b1;
    wfor(2, 1'b1);
    core_irq_any <= 1'b0;
    for (i = 0; i < 4; i++) begin
      wr(`LPW_OFF_CTRL, 32'h2);
      core_lp_req <= 1'b1;
      cyc(1);
      core_lp_req <= 1'b0;
      wfor(1, 1'b0);
      chk("reg_en", 1'b0, regulator_en);
      chk("always_on", 1'b1, always_on_clk_en);
      core_irq_any <= 1'b1;
      cyc(6);
      core_irq_any <= 1'b0;
      chk("pwr", 1'b0, core_pwr_en);
      case (i)
        0: rtc_event <= 1'b1;
        1: standby_wakeup_pin <= 1'b1;
        2: independent_watchdog_rst <= 1'b1;
        default: external_reset_pin_n <= 1'b0;
      endcase
      cyc(4);
      rtc_event <= 1'b0;
      standby_wakeup_pin <= 1'b0;
      independent_watchdog_rst <= 1'b0;
      external_reset_pin_n <= 1'b1;
      wfor(1, 1'b1);
      wfor(3, 1'b0);
      chk("lp_mode", 1'b0, low_power_regulator_mode);
      rd(`LPW_OFF_CTRL, 32'h0);
      rd(`LPW_OFF_STAT, 32'h80);
    end
    wr(`LPW_OFF_STAT, 32'h80);
    rd(`LPW_OFF_STAT, 32'h0);
    wr(`LPW_OFF_CTRL, 32'h4);
    wr(`LPW_OFF_RISE, 32'h8001_0000);
    wr(`LPW_OFF_FALL, 32'h0001_0000);
    wr(`LPW_OFF_MASK, 32'h8001_0000);
    pvd_below <= 1'b1;
    io2_below <= 1'b1;
    cyc(8);
    rd(`LPW_OFF_PEND, 32'h8001_0000);
    rd(`LPW_OFF_STAT, 32'h60);
    chk("io2_off", 1'b1, io2_disable);
    chk("irq", 1'b1, irq);
    wr(`LPW_OFF_PEND, 32'hffff_ffff);
    pvd_below <= 1'b0;
    io2_below <= 1'b0;
    cyc(8);
    rd(`LPW_OFF_PEND, 32'h0001_0000);
    pdr_vdda_low <= 1'b1;
    cyc(6);
    chk("chip_rst", 1'b1, chip_reset);
    pdr_vdda_low <= 1'b0;
    wfor(3, 1'b0);
    opt_vdda_mon_off <= 1'b1;
    pdr_vdda_low <= 1'b1;
    cyc(6);
    chk("chip_rst", 1'b0, chip_reset);
    pdr_vdda_low <= 1'b0;
    por_vdd_low <= 1'b1;
    pdr_vdd_low <= 1'b1;
    cyc(6);
    chk("chip_rst", 1'b1, chip_reset);
    por_vdd_low <= 1'b0;
    pdr_vdd_low <= 1'b0;
    wfor(3, 1'b0);
    summarize;
  end
endmodule : low_power_mode_and_wakeup_ctrl_tb_top
